/* src/dswd_pkg.sv */
// package for the serial command word decoder of a 12-bit output converter
// assumes a single system clock that oversamples the serial link
package dswd_pkg;
    localparam int WORD_BITS = 16;
    localparam int CODE_BITS = 12;
    localparam int CNT_BITS = 5;
    // header and reference field positions
    localparam int POS_REG_HI = 15;
    localparam int POS_SPEED = 14;
    localparam int POS_PWR = 13;
    localparam int POS_REG_LO = 12;
    localparam int POS_REF_HI = 1;
    localparam int POS_REF_LO = 0;
    // register select codes {reg_select_hi, reg_select_lo}
    localparam logic [1:0] SEL_DATA = 2'h0;
    localparam logic [1:0] SEL_CTRL = 2'h3;
    // reference select codes
    localparam logic [1:0] REF_EXT0 = 2'h0;
    localparam logic [1:0] REF_1V024 = 2'h1;
    localparam logic [1:0] REF_2V048 = 2'h2;
    localparam logic [1:0] REF_EXT1 = 2'h3;
    // reset values: latches come up all zero
    localparam logic [CODE_BITS-1:0] CODE_RST = 12'h000;
    localparam logic [1:0] REF_RST = 2'h0;
    localparam logic [CNT_BITS-1:0] CNT_FULL = 5'h10;
    localparam logic [CNT_BITS-1:0] CNT_ZERO = 5'h00;
    // decoded reference source
    typedef enum logic [2:0] {
        DSWD_REF_EXT = 3'b001,
        DSWD_REF_LOW = 3'b010,
        DSWD_REF_HIGH = 3'b100
    } dswd_ref_type;
endpackage : dswd_pkg

/* src/dswd_sync.sv */
// two flip-flop synchroniser with edge detection on the second stage output
// assumes the input is asynchronous to clk_i
`timescale 1ns/100ps
module dswd_sync
    import dswd_pkg::*;
#(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic async_i,
    output logic sync_o,
    output logic rise_o,
    output logic fall_o
);
    logic meta_ff;
    logic sync_ff;
    logic last_ff;

    // first stage feeds only the second stage, to contain metastability
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_ff <= RST_VAL;
            sync_ff <= RST_VAL;
            last_ff <= RST_VAL;
        end else begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end

    assign sync_o = sync_ff;
    assign rise_o = sync_ff & ~last_ff;
    assign fall_o = ~sync_ff & last_ff;
endmodule : dswd_sync

/* src/dswd_decoder.sv */
// serial command word decoder: shifts 16-bit words, updates output code and config
// assumes serial clock well below clk_i/4 (bench uses 5 MHz against 40 MHz)
//
// How it works
// - a data-register word loads its twelve low bits, msb first, as the output code.
// - a control-register word uses only its two lowest bits for the reference.
// - reference codes 00 and 11 pick external, 01 the 1.024 V and 10 the 2.048 V level.
// - a full word reaches the latch on the first serial rising edge after the last bit.
// - the reference setting survives data-register writes.
// - with select low a falling frame sync starts a word, one bit per falling clock edge.
// - the latch loads after sixteen bits, or earlier when frame sync rises.
// - header bits fifteen and twelve pick data (00), control (11) or reserved.
// - header bit fourteen is speed (1 fast) and bit thirteen power down (1 down).
`timescale 1ns/100ps
module dswd_decoder
    import dswd_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic sclk_i,
    input wire logic din_i,
    input wire logic frame_sync_i,
    input wire logic chip_select_n_i,
    output logic [CODE_BITS-1:0] output_code_o,
    output logic [1:0] ref_select_o,
    output logic ref_internal_o,
    output logic ref_high_o,
    output logic speed_select_o,
    output logic power_down_bit_o,
    output logic update_o
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SHIFT = 3'b010,
        ST_WAIT = 3'b100
    } dswd_state_type;

    logic sclk_rise;
    logic sclk_fall;
    logic din_s;
    logic fs_rise;
    logic fs_fall;
    logic cs_n_s;
    logic din_meta_ff;
    logic din_ff;

    ////////////////////////////////////////////////////////////////////////////
    // input synchronisers
    // serial clock parks high between frames; resetting to that level avoids a false edge
    dswd_sync #(.RST_VAL(1'b1)) u_sclk (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .async_i(sclk_i),
        .sync_o(),
        .rise_o(sclk_rise),
        .fall_o(sclk_fall)
    );
    dswd_sync #(.RST_VAL(1'b1)) u_fs (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .async_i(frame_sync_i),
        .sync_o(),
        .rise_o(fs_rise),
        .fall_o(fs_fall)
    );
    dswd_sync #(.RST_VAL(1'b1)) u_cs (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .async_i(chip_select_n_i),
        .sync_o(cs_n_s),
        .rise_o(),
        .fall_o()
    );

    // data needs the same two-stage delay as the clock so it stays aligned
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            din_meta_ff <= 1'b0;
            din_ff <= 1'b0;
        end else begin
            din_meta_ff <= din_i;
            din_ff <= din_meta_ff;
        end
    end
    assign din_s = din_ff;

    ////////////////////////////////////////////////////////////////////////////
    // frame state and shift register
    dswd_state_type state_ff;
    dswd_state_type nxt_state;
    logic [WORD_BITS-1:0] shift_ff;
    logic [CNT_BITS-1:0] cnt_ff;
    logic commit;

    // frame sync falling with select low opens a word
    always_comb begin
        nxt_state = state_ff;
        commit = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                if (fs_fall && !cs_n_s) begin
                    nxt_state = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (cs_n_s) begin
                    nxt_state = ST_IDLE; // select lost: word dropped
                end else if (fs_rise) begin
                    commit = (cnt_ff != CNT_ZERO); // short word
                    nxt_state = ST_IDLE;
                end else if (sclk_fall && cnt_ff == CNT_FULL - 5'h01) begin
                    nxt_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (sclk_rise || fs_rise || cs_n_s) begin
                    commit = 1'b1;
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // msb arrives first, so shift left
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            shift_ff <= '0;
            cnt_ff <= CNT_ZERO;
        end else if (state_ff == ST_IDLE) begin
            cnt_ff <= CNT_ZERO;
        end else if (state_ff == ST_SHIFT && sclk_fall && !fs_rise) begin
            shift_ff <= {shift_ff[WORD_BITS-2:0], din_s};
            cnt_ff <= cnt_ff + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // word decode; a short word is left-aligned by padding zeros below
    logic [WORD_BITS-1:0] word;
    logic [1:0] reg_sel;
    always_comb begin
        word = shift_ff << (CNT_FULL - cnt_ff);
        if (state_ff == ST_WAIT) begin
            word = shift_ff;
        end
        reg_sel = {word[POS_REG_HI], word[POS_REG_LO]};
    end

    logic [CODE_BITS-1:0] code_ff;
    logic [1:0] ref_ff;
    logic speed_ff;
    logic pwr_ff;
    logic update_ff;

    // output latch, loads only on data-register words
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            code_ff <= CODE_RST;
            update_ff <= 1'b0;
        end else begin
            update_ff <= 1'b0;
            if (commit && reg_sel == SEL_DATA) begin
                code_ff <= word[CODE_BITS-1:0];
                update_ff <= 1'b1;
            end
        end
    end

    // reference config held until the next control word
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ref_ff <= REF_RST;
        end else if (commit && reg_sel == SEL_CTRL) begin
            ref_ff <= {word[POS_REF_HI], word[POS_REF_LO]};
        end
    end

    // speed and power header bits ride on every valid word; reserved ignored
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            speed_ff <= 1'b0;
            pwr_ff <= 1'b0;
        end else if (commit && (reg_sel == SEL_DATA || reg_sel == SEL_CTRL)) begin
            speed_ff <= word[POS_SPEED];
            pwr_ff <= word[POS_PWR];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reference decode; both external codes treated alike
    dswd_ref_type ref_src;
    always_comb begin
        case (ref_ff)
            REF_1V024: ref_src = DSWD_REF_LOW;
            REF_2V048: ref_src = DSWD_REF_HIGH;
            default: ref_src = DSWD_REF_EXT;
        endcase
    end

    assign output_code_o = code_ff;
    assign ref_select_o = ref_ff;
    assign ref_internal_o = (ref_src != DSWD_REF_EXT);
    assign ref_high_o = (ref_src == DSWD_REF_HIGH);
    assign speed_select_o = speed_ff;
    assign power_down_bit_o = pwr_ff;
    assign update_o = update_ff;
endmodule : dswd_decoder

/* test/dswd_host_model.sv */
// host serial port model that drives command words into the decoder
// assumes clk_i is the 40 MHz system clock; sclk period is 8 clk_i cycles
`timescale 1ns/100ps
module dswd_host_model (
    input wire logic clk_i,
    output logic sclk_o,
    output logic din_o,
    output logic fs_o,
    output logic cs_n_o
);
    // idle: clock parked high, frame and select inactive
    initial begin
        sclk_o = 1'b1;
        din_o = 1'b0;
        fs_o = 1'b1;
        cs_n_o = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////
    // short words stop after 12 bits and rely on the frame end to commit
    task automatic send(input logic [15:0] w, input logic short_i);
        int n;
        n = short_i ? 12 : 16;
        @(negedge clk_i);
        cs_n_o = 1'b0;
        @(negedge clk_i);
        fs_o = 1'b0;
        for (int i = 15; i > 15 - n; i--) begin
            din_o = w[i];
            repeat (4) @(negedge clk_i);
            sclk_o = 1'b0;
            repeat (4) @(negedge clk_i);
            sclk_o = 1'b1;
        end
        repeat (8) @(negedge clk_i);
        fs_o = 1'b1;
        din_o = ~din_o; // released line must not show a stale bit
        repeat (8) @(negedge clk_i);
        cs_n_o = 1'b1;
    endtask : send
endmodule : dswd_host_model

/* test/dswd_decoder_monitor.sv */
// checker for the serial command word decoder outputs
// assumes binding to dswd_decoder; sees only its ports
`timescale 1ns/100ps
module dswd_decoder_monitor
    import dswd_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic sclk_i,
    input wire logic din_i,
    input wire logic frame_sync_i,
    input wire logic chip_select_n_i,
    input wire logic [CODE_BITS-1:0] output_code_o,
    input wire logic [1:0] ref_select_o,
    input wire logic ref_internal_o,
    input wire logic ref_high_o,
    input wire logic speed_select_o,
    input wire logic power_down_bit_o,
    input wire logic update_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);
    // a commit lands three cycles after a rising pin edge on clock, frame or select
    sequence cause_s;
        ($past(sclk_i, 3) && !$past(sclk_i, 4))
            || ($past(frame_sync_i, 3) && !$past(frame_sync_i, 4))
            || ($past(chip_select_n_i, 3) && !$past(chip_select_n_i, 4));
    endsequence
    ////////////////////////////////////////////////////////////////////////
    ref_int_a: assert property (ref_internal_o == (ref_select_o inside {2'h1, 2'h2}))
        else $error("internal flag disagrees with reference field");
    ref_high_a: assert property (ref_high_o == (ref_select_o == REF_2V048))
        else $error("high level flag disagrees with reference field");
    code_upd_a: assert property ($changed(output_code_o) |-> update_o)
        else $error("output code changed without update pulse");
    upd_pulse_a: assert property (update_o |=> !update_o)
        else $error("update pulse longer than one cycle");
    upd_cause_a: assert property (update_o |-> cause_s)
        else $error("update without a rising link edge");
    ref_keep_a: assert property ($changed(output_code_o) |-> $stable(ref_select_o))
        else $error("data word disturbed reference setting");
    code_keep_a: assert property ($changed(ref_select_o) |-> $stable(output_code_o))
        else $error("control word disturbed output code");
    mode_cause_a: assert property ($changed({speed_select_o, power_down_bit_o}) |-> cause_s)
        else $error("mode bits changed outside a commit");
    cover property (update_o);
    cover property (ref_high_o);
    cover property (power_down_bit_o);
endmodule : dswd_decoder_monitor
bind dswd_decoder dswd_decoder_monitor mon (.clk_i(clk_i), .nrst_i(nrst_i), .sclk_i(sclk_i),
    .din_i(din_i), .frame_sync_i(frame_sync_i), .chip_select_n_i(chip_select_n_i),
    .output_code_o(output_code_o), .ref_select_o(ref_select_o), .ref_internal_o(ref_internal_o),
    .ref_high_o(ref_high_o), .speed_select_o(speed_select_o),
    .power_down_bit_o(power_down_bit_o), .update_o(update_o));

/* test/dswd_decoder_test.sv */
// self-checking bench for the serial command word decoder
// assumes the host model and the bound checker are compiled alongside
`timescale 1ns/100ps
module dswd_decoder_test;
    import dswd_pkg::*;
    logic clk_i;
    logic nrst_i;
    logic sclk, din, fs, cs_n, ref_int, ref_hi, speed_select, power_down_bit, upd;
    logic [CODE_BITS-1:0] code;
    logic [1:0] refsel;
    logic [17:0] obs;
    int fails, cmp_count;
    int upd_n;
    assign obs = {code, refsel, ref_int, ref_hi, speed_select, power_down_bit};
    // count update pulses away from the launching edge
    always @(negedge clk_i) begin
        if (upd === 1'b1) begin
            upd_n++;
        end
    end
    dswd_host_model host (.clk_i(clk_i), .sclk_o(sclk), .din_o(din), .fs_o(fs), .cs_n_o(cs_n));
    dswd_decoder uut (.clk_i(clk_i), .nrst_i(nrst_i), .sclk_i(sclk), .din_i(din),
        .frame_sync_i(fs), .chip_select_n_i(cs_n), .output_code_o(code), .ref_select_o(refsel),
        .ref_internal_o(ref_int), .ref_high_o(ref_hi), .speed_select_o(speed_select),
        .power_down_bit_o(power_down_bit), .update_o(upd));
    ////////////////////////////////////////////////////////////////////////
    // expected outputs; flags derived from the reference field
    function automatic logic [17:0] ex(input logic [11:0] c, input logic [1:0] r,
        input logic s, input logic p);
        return {c, r, (r == 2'h1 || r == 2'h2), (r == 2'h2), s, p};
    endfunction : ex
    task automatic end_sim;
        if (fails == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim
    // one word, short when sh is set, then compare once the commit has landed
    task automatic word(input logic [15:0] w, input logic sh, input logic [17:0] e);
        int n0;
        int exp_n;
        n0 = upd_n;
        exp_n = (w[POS_REG_HI] == 1'b0 && w[POS_REG_LO] == 1'b0) ? 1 : 0;
        host.send(w, sh);
        cmp_count++;
        if (obs !== e) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, obs, e);
            fails++;
        end
        cmp_count++;
        if (upd_n - n0 != exp_n) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, upd_n - n0, exp_n);
            fails++;
        end
    endtask : word
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    // generous limit: a word takes about 150 cycles
    initial begin
        #200000;
        fails++;
        end_sim();
    end
    initial begin
        logic [2:0] i;
        nrst_i = 1'b0;
        repeat (10) @(negedge clk_i);
        nrst_i = 1'b1;
        repeat (4) @(negedge clk_i);
        word(16'hdff6, 1'b0, ex(12'h000, 2'h2, 1'b1, 1'b0));
        word(16'h4abc, 1'b0, ex(12'habc, 2'h2, 1'b1, 1'b0));
        for (i = 3'h0; i < 3'h4; i++) begin
            word({4'hb, 10'h3ff, i[1:0]}, 1'b0, ex(12'habc, i[1:0], 1'b0, 1'b1));
        end
        word(16'h8123, 1'b0, ex(12'habc, 2'h3, 1'b0, 1'b1));
        word(16'h1456, 1'b0, ex(12'habc, 2'h3, 1'b0, 1'b1));
        word(16'h0fff, 1'b0, ex(12'hfff, 2'h3, 1'b0, 1'b0));
        word(16'h6001, 1'b0, ex(12'h001, 2'h3, 1'b1, 1'b1));
        word(16'h0a5f, 1'b1, ex(12'ha50, 2'h3, 1'b0, 1'b0));
        end_sim();
    end
endmodule : dswd_decoder_test
